// ---- logic/atb_timebase.sv ----
// acquisition time base, sampling mode select and trace offset logic
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - horizontal scale steps 1-2-5 from 2 ns to 100 s per division
// - 2 to 20 ns/div forces interleaved sampling at 200 ps spacing
// - 50 ns to 2 us/div uses interleaved only when pushbutton or REG_MODE bit0 selects it
// - 50 ns to 200 ms/div captures the whole record in one pass
// - one-pass capture never samples faster than 10 ns per point
// - 500 ms to 100 s/div samples continuously, rolling right to left
// - readout in one-pass or rolling delivers all 32000 words
// - interleaved readout gives 24000, or 24800 and 25000 at 1 and 2 us
// - vertical offset moves in 0.04 div steps, limited to +/-8 div
// - trace beyond grid shows upward or downward off-screen flag
// - vernier out of detent shows variable flag
// - scale shown in panel status field and displayed trace field
module atb_timebase (
   input wire logic clock, // 25 MHz system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic scale_up, // pin: step to slower scale
   input wire logic scale_down, // pin: step to faster scale
   input wire logic il_button, // pin: interleaved pushbutton
   input wire logic [1:0] ofs_up, // pin: offset knob up, per channel
   input wire logic [1:0] ofs_down, // pin: offset knob down, per channel
   input wire logic [1:0] vernier_out, // pin: vernier out of detent
   input wire logic [1:0] [5:0] vscale_code, // vertical_scale code
   input wire logic trigger, // same-domain trigger from acquisition
   input wire logic [7:0] adc_data, // sample from the digitizer
   input wire logic adc_valid, // sample strobe
   output logic adc_ready, // buffer can take a sample
   output logic [7:0] rd_data, // buffered sample towards display
   output logic rd_valid, // buffered sample valid
   input wire logic rd_ready, // display takes sample
   output logic roll_shift, // shift trace one point left
   input wire logic [7:0] reg_addr, // register address
   input wire logic [15:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [15:0] reg_rdata, // read data, cycle after strobe
   output atb_pkg::atb_setting_t panel_setting, // panel status field
   output atb_pkg::atb_setting_t trace_setting, // displayed trace field
   output atb_pkg::atb_status_t status, // off-screen and vernier flags
   output logic signed [1:0] [8:0] ofs_steps // offset per channel
);
   import atb_pkg::*;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] REG_SCALE = 8'h00; // rw scale index
   localparam logic [7:0] REG_MODE = 8'h04; // rw bit0 interleave select
   localparam logic [7:0] REG_OFS0 = 8'h08; // rw offset ch1
   localparam logic [7:0] REG_OFS1 = 8'h0C; // rw offset ch2
   localparam logic [7:0] REG_STATUS = 8'h10; // ro mode and flags
   localparam logic [7:0] REG_READOUT = 8'h14; // ro readout length

   // ------------------------------------------------------------
   // pin synchronisers: three stages, second and third must agree
   // ------------------------------------------------------------
   localparam int NPIN = 9;
   wire [NPIN-1:0] pin_raw = {vernier_out, ofs_down, ofs_up, il_button,
                              scale_down, scale_up};
   logic [NPIN-1:0] s1_q, s2_q, s3_q, lvl_q;
   always_ff @(posedge clock) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   // filtered level and rising-edge pulses
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         always_ff @(posedge clock) begin
            if (srst) lvl_q[gi] <= 1'b0;
            else if (s2_q[gi] == s3_q[gi]) lvl_q[gi] <= s3_q[gi];
         end
      end
   endgenerate
   wire agree_rise_any = 1'b0;
   wire [NPIN-1:0] lvl_d = lvl_q;
   logic [NPIN-1:0] lvl_prev_q;
   always_ff @(posedge clock) begin
      if (srst) lvl_prev_q <= '0;
      else lvl_prev_q <= lvl_q;
   end
   wire [NPIN-1:0] pulse = lvl_q & ~lvl_prev_q & {NPIN{~agree_rise_any}};
   wire up_p = pulse[0];
   wire dn_p = pulse[1];
   wire il_p = pulse[2];
   wire [1:0] oup_p = pulse[4:3];
   wire [1:0] odn_p = pulse[6:5];
   wire [1:0] vern = lvl_d[8:7];

   // ------------------------------------------------------------
   // register bus decode
   // ------------------------------------------------------------
   wire wr_scale = reg_wr && (reg_addr == REG_SCALE);
   wire wr_mode = reg_wr && (reg_addr == REG_MODE);
   wire [1:0] wr_ofs = {reg_wr && (reg_addr == REG_OFS1),
                        reg_wr && (reg_addr == REG_OFS0)};

   // ------------------------------------------------------------
   // horizontal scale index
   // ------------------------------------------------------------
   logic [5:0] scale_q, scale_d;
   wire [5:0] wscale = reg_wdata[5:0];
   // register write wins over a knob click in the same cycle
   always_comb begin
      scale_d = scale_q;
      if (wr_scale) begin
         scale_d = (wscale > ATB_SCALE_MAX) ? ATB_SCALE_MAX : wscale;
      end else if (up_p && scale_q != ATB_SCALE_MAX) begin
         scale_d = scale_q + 6'h01;
      end else if (dn_p && scale_q != ATB_SCALE_MIN) begin
         scale_d = scale_q - 6'h01;
      end
   end
   always_ff @(posedge clock) begin
      if (srst) scale_q <= ATB_SCALE_RESET;
      else scale_q <= scale_d;
   end

   // ------------------------------------------------------------
   // interleaved selection and mode
   // ------------------------------------------------------------
   wire next_optional = (scale_d > ATB_FORCED_IL_LAST) &&
                        (scale_d <= ATB_OPT_IL_LAST);
   logic il_sel_q;
   always_ff @(posedge clock) begin
      if (srst) il_sel_q <= 1'b0;
      else if (!next_optional) il_sel_q <= 1'b0;
      else if (wr_mode) il_sel_q <= reg_wdata[0];
      else if (il_p) il_sel_q <= ~il_sel_q;
   end
   atb_mode_t mode;
   assign mode = (scale_q <= ATB_FORCED_IL_LAST) ? ATB_MODE_INTERLEAVED :
                 (scale_q <= ATB_OPT_IL_LAST && il_sel_q) ?
                 ATB_MODE_INTERLEAVED :
                 (scale_q >= ATB_ROLL_FIRST) ? ATB_MODE_ROLL :
                 ATB_MODE_ONEPASS;

   // ------------------------------------------------------------
   // scale value in ps: mantissa 1-2-5 times decade
   // ------------------------------------------------------------
   wire [3:0] mant = (scale_q % 6'd3 == 6'd0) ? 4'd2 :
                     (scale_q % 6'd3 == 6'd1) ? 4'd5 : 4'd10;
   wire [5:0] dec = scale_q / 6'd3;
   // 50 bits: a 100 s/div record is 1e15 ps, too big for the 40-bit fields
   logic [49:0] scale_ps;
   always_comb begin
      scale_ps = 50'h3E8 * 50'(mant);
      for (int i = 0; i < 12; i++) begin
         if (6'(i) < dec) scale_ps = scale_ps * 50'd10;
      end
   end
   // record time is ten divisions
   wire [49:0] rec_ps = scale_ps * 50'(ATB_DIVS_PER_RECORD);

   // ------------------------------------------------------------
   // point interval, displayed points, readout length
   // ------------------------------------------------------------
   wire [39:0] il_mult = (scale_q == ATB_SCALE_2US) ? 40'd4 :
                         (scale_q == ATB_SCALE_1US) ? 40'd2 : 40'd1;
   wire slow = (scale_q >= ATB_SCALE_50US);
   wire [49:0] slow_q = scale_ps / 50'(ATB_POINTS_PER_SCALE);
   wire [39:0] slow_ps = slow_q[39:0];
   wire is_il = (mode == ATB_MODE_INTERLEAVED);
   wire [39:0] point_ps = is_il ? ATB_IL_POINT_PS * il_mult :
                          slow ? slow_ps : ATB_ONEPASS_MIN_PS;
   wire [49:0] pts_raw = rec_ps / 50'(point_ps);
   wire [15:0] points = (!is_il && slow) ? ATB_POINTS_FULL :
                        pts_raw[15:0];
   wire [15:0] readout = !is_il ? ATB_READ_FULL :
                         (scale_q == ATB_SCALE_1US) ? ATB_READ_IL_1US :
                         (scale_q == ATB_SCALE_2US) ? ATB_READ_IL_2US :
                         ATB_READ_IL;
   atb_setting_t cur;
   assign cur = '{scale: scale_q, mode: mode, point_ps: point_ps,
                  points: points, readout_words: readout};

   // ------------------------------------------------------------
   // display fields: panel live, trace field latched on trigger
   // ------------------------------------------------------------
   atb_setting_t trace_q;
   always_ff @(posedge clock) begin
      if (srst) begin
         panel_setting <= '0;
         trace_q <= '0;
      end else begin
         panel_setting <= cur;
         if (trigger) trace_q <= cur;
      end
   end
   assign trace_setting = trace_q;

   // ------------------------------------------------------------
   // rolling display: each sample shifts the trace left
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) roll_shift <= 1'b0;
      else roll_shift <= (mode == ATB_MODE_ROLL) && adc_valid && adc_ready;
   end

   // sample buffer; back-pressure reaches the digitizer through adc_ready
   atb_fifo #(.WIDTH(ATB_SAMPLE_W), .DEPTH(ATB_FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .srst(srst),
      .in_data(adc_data),
      .in_valid(adc_valid),
      .in_ready(adc_ready),
      .out_data(rd_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready)
   );

   // ------------------------------------------------------------
   // vertical offset per channel, saturating at one grid height
   // ------------------------------------------------------------
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         logic signed [8:0] ofs_q, ofs_d;
         // clamp on the full word so large negatives do not wrap positive
         wire signed [15:0] wv = reg_wdata;
         wire signed [15:0] lim = 16'(ATB_OFS_LIMIT);
         wire signed [15:0] wc = (wv > lim) ? lim :
                                 (wv < -lim) ? -lim : wv;
         always_comb begin
            ofs_d = ofs_q;
            if (wr_ofs[gi]) begin
               ofs_d = wc[8:0];
            end else if (oup_p[gi] && ofs_q < ATB_OFS_LIMIT) begin
               ofs_d = ofs_q + 9'sd1;
            end else if (odn_p[gi] && ofs_q > -ATB_OFS_LIMIT) begin
               ofs_d = ofs_q - 9'sd1;
            end
         end
         always_ff @(posedge clock) begin
            if (srst) ofs_q <= ATB_OFS_RESET;
            else ofs_q <= ofs_d;
         end
         assign ofs_steps[gi] = ofs_q;
         // off grid once beyond half a grid height from centre
         assign status.off_up[gi] = (ofs_q > ATB_OFS_GRID);
         assign status.off_down[gi] = (ofs_q < -ATB_OFS_GRID);
         // vernier extends range; the flag alone is this block's job
         assign status.var_flag[gi] = vern[gi];
      end
   endgenerate

   // ------------------------------------------------------------
   // register read: data in the cycle after the strobe
   // ------------------------------------------------------------
   logic [15:0] rmux;
   always_comb begin
      unique case (reg_addr)
         REG_SCALE: rmux = {10'h000, scale_q};
         REG_MODE: rmux = {15'h0000, il_sel_q};
         REG_OFS0: rmux = {{7{ofs_steps[0][8]}}, ofs_steps[0]};
         REG_OFS1: rmux = {{7{ofs_steps[1][8]}}, ofs_steps[1]};
         REG_STATUS: rmux = {8'h00, status, mode};
         REG_READOUT: rmux = readout;
         default: rmux = 16'h0000;
      endcase
   end
   always_ff @(posedge clock) begin
      if (srst) reg_rdata <= 16'h0000;
      else reg_rdata <= reg_rd ? rmux : 16'h0000;
   end
   wire unused_vscale = ^vscale_code;
endmodule : atb_timebase

// ---- logic/atb_pkg.sv ----
// package of constants and carrier types for the acquisition time base block
package atb_pkg;
   // ------------------------------------------------------------
   // horizontal scale: index 0 = 2 ns/div ... index 32 = 100 s/div
   // ------------------------------------------------------------
   localparam logic [5:0] ATB_SCALE_MIN = 6'h00; // 2 ns/div
   localparam logic [5:0] ATB_SCALE_MAX = 6'h20; // 100 s/div
   localparam logic [5:0] ATB_SCALE_RESET = 6'h0D; // 50 us/div
   localparam logic [5:0] ATB_FORCED_IL_LAST = 6'h03; // 20 ns/div
   localparam logic [5:0] ATB_OPT_IL_LAST = 6'h09; // 2 us/div
   localparam logic [5:0] ATB_ROLL_FIRST = 6'h19; // 500 ms/div
   localparam logic [5:0] ATB_SCALE_1US = 6'h08;
   localparam logic [5:0] ATB_SCALE_2US = 6'h09;
   localparam logic [5:0] ATB_SCALE_50US = 6'h0D;
   // ------------------------------------------------------------
   // timing, all intervals in picoseconds
   // ------------------------------------------------------------
   localparam logic [39:0] ATB_IL_POINT_PS = 40'h00000000C8; // 200 ps
   localparam logic [39:0] ATB_ONEPASS_MIN_PS = 40'h0000002710; // 10 ns
   localparam logic [15:0] ATB_POINTS_PER_SCALE = 16'h09C4; // 2500
   localparam logic [15:0] ATB_POINTS_FULL = 16'h61A8; // 25000
   localparam logic [15:0] ATB_READ_FULL = 16'h7D00; // 32000
   localparam logic [15:0] ATB_READ_IL = 16'h5DC0; // 24000
   localparam logic [15:0] ATB_READ_IL_1US = 16'h60E0; // 24800
   localparam logic [15:0] ATB_READ_IL_2US = 16'h61A8; // 25000
   localparam logic [15:0] ATB_DIVS_PER_RECORD = 16'h000A; // 10 div
   // ------------------------------------------------------------
   // vertical offset in 0.04 div steps, +/-8 div = +/-200 steps
   // ------------------------------------------------------------
   localparam logic signed [8:0] ATB_OFS_LIMIT = 9'sh0C8; // 200 steps
   localparam logic signed [8:0] ATB_OFS_GRID = 9'sh064; // 4 div half grid
   localparam logic signed [8:0] ATB_OFS_RESET = 9'sh000;
   localparam int ATB_FIFO_DEPTH = 8;
   localparam int ATB_SAMPLE_W = 8;

   typedef enum logic [1:0] {
      ATB_MODE_ONEPASS = 2'b00,
      ATB_MODE_INTERLEAVED = 2'b01,
      ATB_MODE_ROLL = 2'b10
   } atb_mode_t;

   // settings presented to the display fields
   typedef struct packed {
      logic [5:0] scale;
      atb_mode_t mode;
      logic [39:0] point_ps;
      logic [15:0] points;
      logic [15:0] readout_words;
   } atb_setting_t;

   // per channel off-screen and vernier indications
   typedef struct packed {
      logic [1:0] off_up;
      logic [1:0] off_down;
      logic [1:0] var_flag;
   } atb_status_t;
endpackage : atb_pkg

// ---- logic/atb_fifo.sv ----
// small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module atb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock, // system clock
   input wire logic srst, // synchronous reset
   input wire logic [WIDTH-1:0] in_data, // write data
   input wire logic in_valid, // write request
   output logic in_ready, // space available
   output logic [WIDTH-1:0] out_data, // read data
   output logic out_valid, // data available
   input wire logic out_ready // reader takes word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   // storage and pointers; pointers wrap since depth is a power of two
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q <= wr_q + 1'b1;
         end
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : atb_fifo

// ---- verification/atb_timebase_properties.sv ----
// port checks on the acquisition time base
`timescale 1ns/1ps
module atb_timebase_properties (
   input wire logic clock, // clock
   input wire logic srst, // reset
   input wire logic trigger, // latch pulse
   input wire logic [1:0] vernier_out, // vernier pins
   input wire logic adc_valid, // offered
   input wire logic adc_ready, // taken
   input wire logic roll_shift, // roll step
   input wire atb_pkg::atb_setting_t panel_setting, // panel
   input wire atb_pkg::atb_setting_t trace_setting, // trace
   input wire atb_pkg::atb_status_t status, // flags
   input wire logic signed [1:0] [8:0] ofs_steps // offsets
);
   import atb_pkg::*;
   logic [1:0] live_q;
   logic live;
   atb_setting_t p;
   // settings read zero just after reset, so wait them out
   always_ff @(posedge clock) begin
      if (srst) live_q <= 2'h0;
      else if (live_q != 2'h3) live_q <= live_q + 2'h1;
   end
   assign live = live_q == 2'h3;
   assign p = panel_setting;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_vern_held;
      vernier_out[1] [*8];
   endsequence
   sequence s_trig_calm;
      trigger ##1 $stable(panel_setting);
   endsequence
   a_forced_il: assert property (live && p.scale <= ATB_FORCED_IL_LAST |->
      p.mode == ATB_MODE_INTERLEAVED && p.point_ps == ATB_IL_POINT_PS)
      else $error("fast scale not interleaved");
   a_mid_onepass: assert property (live && p.scale > ATB_OPT_IL_LAST
      && p.scale < ATB_ROLL_FIRST |-> p.mode == ATB_MODE_ONEPASS)
      else $error("mid scale not one pass");
   a_roll_range: assert property (live && p.scale >= ATB_ROLL_FIRST
      |-> p.mode == ATB_MODE_ROLL) else $error("slow scale not rolling");
   a_onepass_rate: assert property (live && p.mode == ATB_MODE_ONEPASS
      |-> p.point_ps >= ATB_ONEPASS_MIN_PS) else $error("one pass too fast");
   a_full_readout: assert property (live && p.mode != ATB_MODE_INTERLEAVED
      |-> p.readout_words == ATB_READ_FULL) else $error("readout short");
   a_il_readout: assert property (live && p.mode == ATB_MODE_INTERLEAVED
      && p.scale < ATB_SCALE_1US |-> p.readout_words == ATB_READ_IL)
      else $error("interleaved readout wrong");
   a_ofs_limit: assert property ($signed(ofs_steps[1]) <= ATB_OFS_LIMIT
      && $signed(ofs_steps[1]) >= -ATB_OFS_LIMIT) else $error("offset range");
   a_off_up: assert property ($signed(ofs_steps[0]) > ATB_OFS_GRID
      |-> ##[0:1] status.off_up[0]) else $error("no off-screen flag");
   a_var_flag: assert property (s_vern_held |-> ##[0:2] status.var_flag[1])
      else $error("no variable flag");
   a_trace_latch: assert property (s_trig_calm |-> ##[0:1]
      trace_setting == panel_setting) else $error("trace field stale");
   a_roll_step: assert property (roll_shift |-> $past(adc_valid && adc_ready)
      && p.mode == ATB_MODE_ROLL) else $error("stray roll shift");
endmodule : atb_timebase_properties
bind atb_timebase atb_timebase_properties u_props (.clock, .srst, .trigger,
   .vernier_out, .adc_valid, .adc_ready, .roll_shift, .panel_setting,
   .trace_setting, .status, .ofs_steps);

// ---- verification/atb_stream_model.sv ----
// digitizer source and display sink on the buffered sample path
`timescale 1ns/1ps
module atb_stream_model (
   input wire logic clock, // clock
   input wire logic srst, // reset
   input wire logic push_en, // offer samples
   input wire logic take_en, // accept samples
   input wire logic adc_ready, // buffer space
   input wire logic [7:0] rd_data, // buffer head
   input wire logic rd_valid, // head valid
   output logic [7:0] adc_data, // ramp sample
   output logic adc_valid, // sample valid
   output logic rd_ready, // sink ready
   output int sent, // accepted count
   output int got, // drained count
   output int errs // order faults
);
   // an offered word stays up until taken, even once push_en drops
   always_ff @(posedge clock) begin
      if (srst) begin
         adc_data <= 8'h00;
         adc_valid <= 1'b0;
         rd_ready <= 1'b0;
         sent <= 0;
         got <= 0;
         errs <= 0;
      end else begin
         adc_valid <= push_en || (adc_valid && !adc_ready);
         rd_ready <= take_en;
         if (adc_valid && adc_ready) begin
            sent <= sent + 1;
            adc_data <= adc_data + 8'h01;
         end
         if (rd_valid && rd_ready) begin
            got <= got + 1;
            if (rd_data !== got[7:0]) errs <= errs + 1;
         end
      end
   end
endmodule : atb_stream_model

// ---- verification/atb_timebase_tb_top.sv ----
// self-checking bench for the acquisition time base
`timescale 1ns/1ps
module atb_timebase_tb_top;
   import atb_pkg::*;
   logic clock, srst, scale_up, il_button, trigger, reg_wr, reg_rd;
   logic adc_valid, adc_ready, rd_valid, rd_ready, roll_shift;
   logic push_en, take_en;
   logic [1:0] vernier_out;
   logic [7:0] reg_addr, adc_data, rd_data;
   logic [15:0] reg_wdata, reg_rdata, rv;
   atb_setting_t panel_setting, trace_setting;
   atb_status_t status;
   logic signed [1:0] [8:0] ofs_steps;
   int mismatches, comparisons, sent, got, errs, shifts;
   atb_timebase dut (.clock, .srst, .scale_up, .scale_down(1'h0),
      .il_button, .ofs_up(2'h0), .ofs_down(2'h0), .vernier_out,
      .vscale_code(12'h000), .trigger, .adc_data, .adc_valid, .adc_ready,
      .rd_data, .rd_valid, .rd_ready, .roll_shift, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .panel_setting, .trace_setting,
      .status, .ofs_steps);
   atb_stream_model u_stream (.clock, .srst, .push_en, .take_en, .adc_ready,
      .rd_data, .rd_valid, .adc_data, .adc_valid, .rd_ready, .sent, .got,
      .errs);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // count roll steps; expected one per accepted sample
   always @(posedge clock) if (roll_shift === 1'b1) shifts++;
   task automatic check(input logic [63:0] g, input logic [63:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
      end
   endtask : check
   // write, then let the setting reach the panel field
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask : rd
   // pins pass a synchroniser and filter, so hold and wait long
   task automatic press(input bit btn);
      @(posedge clock);
      if (btn) il_button <= 1'b1;
      else scale_up <= 1'b1;
      repeat (8) @(posedge clock);
      il_button <= 1'b0;
      scale_up <= 1'b0;
      repeat (10) @(posedge clock);
      #1;
   endtask : press
   // interval for 50 us/div and slower: step time over 2500
   function automatic logic [63:0] exp_ps(input int s);
      logic [63:0] p;
      p = (s % 3 == 0) ? 64'h7D0 : (s % 3 == 1) ? 64'h1388 : 64'h2710;
      repeat (s / 3) p = p * 64'hA;
      return p / 64'h9C4;
   endfunction : exp_ps
   task automatic t_scales;
      rd(8'h14);
      check(rv, 16'h7D00);
      rd(8'h20);
      check(rv, 16'h0000);
      for (int s = 0; s <= 32; s++) begin
         wr(8'h00, 16'(s));
         check(panel_setting.scale, s);
         if (s <= 3) begin
            check(panel_setting.mode, ATB_MODE_INTERLEAVED);
            check(panel_setting.point_ps, 40'hC8);
            check(panel_setting.readout_words, 16'h5DC0);
         end else begin
            check(panel_setting.mode, s >= 25 ? 2'h2 : 2'h0);
            check(panel_setting.point_ps, s < 13 ? 64'h2710 : exp_ps(s));
            check(panel_setting.readout_words, 16'h7D00);
         end
         if (s >= 13) check(panel_setting.points, 16'h61A8);
      end
      wr(8'h00, 16'h003F);
      rd(8'h00);
      check(rv, 16'h0020);
      $display("test scales done");
   endtask : t_scales
   task automatic t_modes;
      wr(8'h00, 16'h0008);
      wr(8'h04, 16'h0001);
      check(panel_setting.mode, ATB_MODE_INTERLEAVED);
      check(panel_setting.readout_words, 16'h60E0);
      wr(8'h00, 16'h0009);
      check(panel_setting.readout_words, 16'h61A8);
      wr(8'h00, 16'h000A);
      wr(8'h00, 16'h0009);
      check(panel_setting.mode, ATB_MODE_ONEPASS);
      press(1'b1);
      check(panel_setting.mode, ATB_MODE_INTERLEAVED);
      wr(8'h00, 16'h0019);
      press(1'b0);
      check(panel_setting.scale, 6'h1A);
      $display("test modes done");
   endtask : t_modes
   task automatic t_offset;
      wr(8'h08, 16'h0065);
      check(status.off_up, 2'h1);
      wr(8'h0C, 16'hFED4);
      check(ofs_steps[1], 9'h138);
      check(status.off_down, 2'h2);
      vernier_out <= 2'h2;
      repeat (10) @(posedge clock);
      rd(8'h10);
      check(rv, 16'h006A);
      $display("test offset done");
   endtask : t_offset
   task automatic t_trigger;
      wr(8'h00, 16'h0004);
      trigger <= 1'b1;
      @(posedge clock);
      trigger <= 1'b0;
      wr(8'h00, 16'h0005);
      check(trace_setting.scale, 6'h04);
      check(panel_setting.scale, 6'h05);
      $display("test trigger done");
   endtask : t_trigger
   // fill against a stalled sink, then drain in order
   task automatic t_fifo;
      wr(8'h00, 16'h0019);
      push_en <= 1'b1;
      repeat (20) @(posedge clock);
      #1;
      check(adc_ready, 1'b0);
      check(sent, 8);
      push_en <= 1'b0;
      take_en <= 1'b1;
      repeat (20) @(posedge clock);
      #1;
      check(got, 9);
      check(errs, 0);
      check(shifts, 9);
      $display("test fifo done");
   endtask : t_fifo
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      {srst, scale_up, il_button, trigger, reg_wr, reg_rd} = 6'h20;
      {push_en, take_en, vernier_out, reg_addr, reg_wdata} = 28'h0;
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      t_scales;
      t_modes;
      t_offset;
      t_trigger;
      t_fifo;
      tally_and_finish;
   end
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (8000) @(posedge clock);
      mismatches++;
      tally_and_finish;
   end
endmodule : atb_timebase_tb_top
